// File: inc/pllcg_cfg.svh
// Offsets, field positions, reset values and counts of the loop controller
// Assumes an 8-bit register address and 8-bit register data
`ifndef PLLCG_CFG_SVH
`define PLLCG_CFG_SVH
`define PLLCG_OFS_CTRL   8'h00
`define PLLCG_OFS_BW     8'h01
`define PLLCG_OFS_MULTL  8'h02
`define PLLCG_OFS_MULTH  8'h03
`define PLLCG_OFS_RANGE  8'h04
`define PLLCG_OFS_RDIV   8'h05
`define PLLCG_CTRL_IE    7
`define PLLCG_CTRL_FLAG  6
`define PLLCG_CTRL_PWR   5
`define PLLCG_CTRL_SEL   4
`define PLLCG_CTRL_PRE   3:2
`define PLLCG_CTRL_EXP   1:0
`define PLLCG_BW_AUTO    7
`define PLLCG_BW_LOCK    6
`define PLLCG_BW_TRACK   5
`define PLLCG_RST_MULT   12'h040
`define PLLCG_RST_RANGE  8'h40
`define PLLCG_RST_RDIV   4'h1
`define PLLCG_SWITCH_EDGES 2'h3
`define PLLCG_NOM_FREQ_HZ 32'h0000_9600
`endif

// File: inc/pllcg_pkg.sv
// Types shared by the loop controller
// Assumes the header of constants is included beside it
package pllcg_pkg;
   typedef enum logic [2:0] {
      PLLCG_RUN  = 3'b001,
      PLLCG_HOLD = 3'b010,
      PLLCG_SWAP = 3'b100
   } pllcg_state_t;

   typedef struct packed {
      logic       intEn;
      logic       power;
      logic       baseSel;
      logic [1:0] preScale;
      logic [1:0] rangeExp;
   } pllcg_ctrl_t;

   typedef struct packed {
      logic lock;
      logic track;
   } pllcg_det_t;
endpackage : pllcg_pkg

// File: core/pllcg_top.sv
// Digital control of the clock generator: dividers, lock detector, base clock
// Assumes crystal and VCO clocks arrive as asynchronous pins, well below clk/4
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "pllcg_cfg.svh"
module pllcg_top
   import pllcg_pkg::*;
#(
   parameter int N_W      = 12,
   parameter int R_W      = 4,
   parameter int PER_W    = 20,
   parameter int ACQ_TOL  = 64,
   parameter int LOCK_TOL = 8
)
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // Oscillator and analog side
   input  wire logic        oscillatorEnable,
   input  wire logic        crystalClock,
   input  wire logic        vcoClock,
   output logic             oscRun,
   output logic             loopReferenceClock,
   output logic             finalReferenceClock,
   output logic             vcoFeedbackClock,
   output logic             pumpUp,
   output logic             pumpDown,
   output logic             filterTrack,
   output logic [31:0]      vcoCentreHz,
   output logic             loopPower,
   output logic             baseClock,
   output logic             lockIrq,
   // Register port
   input  wire logic [7:0]  regAddr,
   input  wire logic [7:0]  regWdata,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic [7:0]       regRdata
);

   if (N_W < 9 || N_W > 16 || R_W < 1 || R_W > 8 || PER_W < 8)
      $error("pllcg_top: unsupported width parameters");
   if (LOCK_TOL > ACQ_TOL)
      $error("pllcg_top: lock window wider than acquisition window");

   // Zero programmed is taken as one
   function automatic logic [15:0] nz(input logic [15:0] v);
      nz = (v == 16'h0) ? 16'h1 : v;
   endfunction : nz

   function automatic logic [PER_W-1:0] absDiff(input logic [PER_W-1:0] a,
                                                input logic [PER_W-1:0] b);
      absDiff = (a > b) ? a - b : b - a;
   endfunction : absDiff

   //--------------------------------------------------------------------
   // Pin synchronisers
   //--------------------------------------------------------------------
   logic [2:0] xtalSync_reg;
   logic [2:0] vcoSync_reg;
   logic       xtalEdge;
   logic       vcoEdge;

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         xtalSync_reg <= 3'h0;
         vcoSync_reg  <= 3'h0;
      end
      else
      begin
         xtalSync_reg <= {xtalSync_reg[1:0], crystalClock};
         vcoSync_reg  <= {vcoSync_reg[1:0], vcoClock};
      end
   end

   // Crystal edges only count while the oscillator runs
   assign xtalEdge = oscRun && xtalSync_reg[1] && !xtalSync_reg[2];
   assign vcoEdge  = vcoSync_reg[1] && !vcoSync_reg[2];

   //--------------------------------------------------------------------
   // Registers
   //--------------------------------------------------------------------
   pllcg_ctrl_t     ctrl_reg;
   logic            auto_reg;
   logic            trackBit_reg;
   logic            flag_reg;
   logic [N_W-1:0]  mult_reg;
   logic [7:0]      range_reg;
   logic [R_W-1:0]  rdiv_reg;
   pllcg_det_t      detSync1_reg;
   pllcg_det_t      detSync2_reg;
   logic            lockPrev_reg;
   logic            wrCtrl;
   logic            conflict;
   logic            lockRd;
   logic            trackRd;
   logic            lockChange;
   logic            flagClr;

   assign wrCtrl   = regWr && (regAddr == `PLLCG_OFS_CTRL);
   assign conflict = (regWdata[`PLLCG_CTRL_PWR] != ctrl_reg.power) &&
                     (regWdata[`PLLCG_CTRL_SEL] != ctrl_reg.baseSel);
   assign lockRd   = auto_reg && detSync2_reg.lock;
   assign trackRd  = auto_reg ? detSync2_reg.track : trackBit_reg;
   assign lockChange = auto_reg && (detSync2_reg.lock != lockPrev_reg);
   assign flagClr  = regRd && (regAddr == `PLLCG_OFS_CTRL);

   always_ff @(posedge clk)
   begin
      if (!rstn)
         ctrl_reg <= '0;
      else
      begin
         if (wrCtrl)
         begin
            ctrl_reg.intEn <= auto_reg && regWdata[`PLLCG_CTRL_IE];
            if (!conflict)
            begin
               // Loop stays on while the VCO drives the base clock
               ctrl_reg.power <= ctrl_reg.baseSel || regWdata[`PLLCG_CTRL_PWR];
               ctrl_reg.baseSel <= ctrl_reg.power && (range_reg != 8'h0) &&
                                   regWdata[`PLLCG_CTRL_SEL];
            end
            if (!ctrl_reg.power)
            begin
               ctrl_reg.preScale <= regWdata[`PLLCG_CTRL_PRE];
               ctrl_reg.rangeExp <= regWdata[`PLLCG_CTRL_EXP];
            end
         end
         if (!auto_reg)
            ctrl_reg.intEn <= 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         auto_reg     <= 1'b0;
         trackBit_reg <= 1'b0;
      end
      else if (regWr && (regAddr == `PLLCG_OFS_BW))
      begin
         auto_reg <= regWdata[`PLLCG_BW_AUTO];
         if (!auto_reg)
            trackBit_reg <= regWdata[`PLLCG_BW_TRACK];
      end
   end

   // Frozen while the loop runs so the dividers never see a mid-lock change
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         mult_reg  <= N_W'(`PLLCG_RST_MULT);
         range_reg <= `PLLCG_RST_RANGE;
         rdiv_reg  <= R_W'(`PLLCG_RST_RDIV);
      end
      else if (regWr && !ctrl_reg.power)
      begin
         if (regAddr == `PLLCG_OFS_MULTL)
            mult_reg[7:0] <= regWdata;
         if (regAddr == `PLLCG_OFS_MULTH)
            mult_reg[N_W-1:8] <= regWdata[N_W-9:0];
         if (regAddr == `PLLCG_OFS_RANGE)
            range_reg <= regWdata;
         if (regAddr == `PLLCG_OFS_RDIV)
            rdiv_reg <= regWdata[R_W-1:0];
      end
   end

   // Set wins over the clearing read
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         flag_reg     <= 1'b0;
         lockPrev_reg <= 1'b0;
      end
      else
      begin
         lockPrev_reg <= detSync2_reg.lock;
         if (lockChange)
            flag_reg <= 1'b1;
         else if (flagClr || !auto_reg)
            flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
         regRdata <= 8'h0;
      else if (!regRd)
         regRdata <= 8'h0;
      else
      begin
         unique case (regAddr)
            `PLLCG_OFS_CTRL:
               regRdata <= {ctrl_reg.intEn, flag_reg && auto_reg, ctrl_reg.power,
                            ctrl_reg.baseSel, ctrl_reg.preScale, ctrl_reg.rangeExp};
            `PLLCG_OFS_BW:    regRdata <= {auto_reg, lockRd, trackRd, 5'h0};
            `PLLCG_OFS_MULTL: regRdata <= mult_reg[7:0];
            `PLLCG_OFS_MULTH: regRdata <= 8'(mult_reg[N_W-1:8]);
            `PLLCG_OFS_RANGE: regRdata <= range_reg;
            `PLLCG_OFS_RDIV:  regRdata <= 8'(rdiv_reg);
            default:          regRdata <= 8'h0;
         endcase
      end
   end

   //--------------------------------------------------------------------
   // Oscillator, reference and feedback dividers
   //--------------------------------------------------------------------
   logic [R_W-1:0] refCnt_reg;
   logic [2:0]     preCnt_reg;
   logic [N_W-1:0] modCnt_reg;
   logic [2:0]     preTop;
   logic           preTick;
   logic           rdvTick;
   logic           fbTick;

   assign preTop  = 3'((4'h1 << ctrl_reg.preScale) - 4'h1);
   assign preTick = vcoEdge && (preCnt_reg == preTop);
   assign rdvTick = xtalEdge && (16'(refCnt_reg) + 16'h1 >= nz(16'(rdiv_reg)));
   assign fbTick  = preTick && (16'(modCnt_reg) + 16'h1 >= nz(16'(mult_reg)));

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         oscRun             <= 1'b0;
         loopReferenceClock <= 1'b0;
      end
      else
      begin
         oscRun             <= oscillatorEnable;
         loopReferenceClock <= oscRun && xtalSync_reg[2];
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn || !ctrl_reg.power)
      begin
         refCnt_reg          <= '0;
         finalReferenceClock <= 1'b0;
      end
      else
      begin
         finalReferenceClock <= rdvTick;
         if (rdvTick)
            refCnt_reg <= '0;
         else if (xtalEdge)
            refCnt_reg <= refCnt_reg + R_W'(1);
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn || !ctrl_reg.power)
      begin
         preCnt_reg       <= 3'h0;
         modCnt_reg       <= '0;
         vcoFeedbackClock <= 1'b0;
      end
      else
      begin
         vcoFeedbackClock <= fbTick;
         if (preTick)
            preCnt_reg <= 3'h0;
         else if (vcoEdge)
            preCnt_reg <= preCnt_reg + 3'h1;
         if (fbTick)
            modCnt_reg <= '0;
         else if (preTick)
            modCnt_reg <= modCnt_reg + N_W'(1);
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
         vcoCentreHz <= 32'h0;
      else
         vcoCentreHz <= ({24'h0, range_reg} * `PLLCG_NOM_FREQ_HZ) << ctrl_reg.rangeExp;
   end

   //--------------------------------------------------------------------
   // Phase detector
   //--------------------------------------------------------------------
   // Leading edge opens a pulse, the other edge closes both
   always_ff @(posedge clk)
   begin
      if (!rstn || !ctrl_reg.power)
      begin
         pumpUp   <= 1'b0;
         pumpDown <= 1'b0;
      end
      else if (rdvTick && fbTick)
      begin
         pumpUp   <= 1'b0;
         pumpDown <= 1'b0;
      end
      else if (rdvTick)
      begin
         pumpUp   <= !pumpDown;
         pumpDown <= 1'b0;
      end
      else if (fbTick)
      begin
         pumpDown <= !pumpUp;
         pumpUp   <= 1'b0;
      end
   end

   //--------------------------------------------------------------------
   // Lock detector
   //--------------------------------------------------------------------
   // Periods counted in clk cycles; resolution is limited by the clk rate
   logic [PER_W-1:0] refAge_reg;
   logic [PER_W-1:0] fbAge_reg;
   logic [PER_W-1:0] fbPer_reg;
   pllcg_det_t       detRaw_reg;
   logic [PER_W-1:0] perDiff;

   assign perDiff = absDiff(refAge_reg, fbPer_reg);

   always_ff @(posedge clk)
   begin
      if (!rstn || !ctrl_reg.power)
      begin
         refAge_reg <= '0;
         fbAge_reg  <= '0;
         fbPer_reg  <= '0;
         detRaw_reg <= '0;
      end
      else
      begin
         if (fbTick)
            fbPer_reg <= fbAge_reg;
         fbAge_reg  <= fbTick ? '0 : fbAge_reg + PER_W'(!(&fbAge_reg));
         refAge_reg <= rdvTick ? '0 : refAge_reg + PER_W'(!(&refAge_reg));
         if (rdvTick)
         begin
            detRaw_reg.track <= perDiff <= PER_W'(ACQ_TOL);
            detRaw_reg.lock  <= perDiff <= PER_W'(LOCK_TOL);
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         detSync1_reg <= '0;
         detSync2_reg <= '0;
      end
      else
      begin
         detSync1_reg <= detRaw_reg;
         detSync2_reg <= detSync1_reg;
      end
   end

   // Filter mode: the detector steers it in auto mode, software otherwise
   assign filterTrack = trackRd;
   assign loopPower   = ctrl_reg.power;
   assign lockIrq     = ctrl_reg.intEn && flag_reg;

   //--------------------------------------------------------------------
   // Base clock selector
   //--------------------------------------------------------------------
   pllcg_state_t selState_reg;
   logic         srcVco_reg;
   logic [1:0]   oldCnt_reg;
   logic [1:0]   newCnt_reg;
   logic         oldEdge;
   logic         newEdge;
   logic         srcEdge;
   logic         oldGone;
   logic         newGone;

   assign oldEdge = srcVco_reg ? vcoEdge : xtalEdge;
   assign newEdge = srcVco_reg ? xtalEdge : vcoEdge;
   // A stopped source gives no edges; waiting on it would freeze the base clock
   assign oldGone = srcVco_reg ? !ctrl_reg.power : !oscRun;
   assign newGone = srcVco_reg ? !oscRun : !ctrl_reg.power;
   assign srcEdge = srcVco_reg ? vcoEdge : xtalEdge;

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         selState_reg <= PLLCG_RUN;
         srcVco_reg   <= 1'b0;
         oldCnt_reg   <= 2'h0;
         newCnt_reg   <= 2'h0;
      end
      else
      begin
         unique case (selState_reg)
            PLLCG_RUN:
            begin
               oldCnt_reg <= 2'h0;
               newCnt_reg <= 2'h0;
               if (ctrl_reg.baseSel != srcVco_reg)
                  selState_reg <= PLLCG_HOLD;
            end
            PLLCG_HOLD:
            begin
               if ((oldEdge || oldGone) && oldCnt_reg != `PLLCG_SWITCH_EDGES)
                  oldCnt_reg <= oldCnt_reg + 2'h1;
               if ((newEdge || newGone) && newCnt_reg != `PLLCG_SWITCH_EDGES)
                  newCnt_reg <= newCnt_reg + 2'h1;
               if (oldCnt_reg == `PLLCG_SWITCH_EDGES &&
                   newCnt_reg == `PLLCG_SWITCH_EDGES)
                  selState_reg <= PLLCG_SWAP;
            end
            PLLCG_SWAP:
            begin
               srcVco_reg   <= !srcVco_reg;
               selState_reg <= PLLCG_RUN;
            end
            default: selState_reg <= PLLCG_RUN;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
         baseClock <= 1'b0;
      else if (selState_reg == PLLCG_RUN && srcEdge)
         baseClock <= !baseClock;
   end

   //--------------------------------------------------------------------
   // Checks
   //--------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   a_sel_needs_power: assert property (ctrl_reg.baseSel |-> ctrl_reg.power &&
                                       range_reg != 8'h0)
      else $error("select set while loop off or range zero");
   a_power_held_on: assert property (ctrl_reg.baseSel |=> ctrl_reg.power)
      else $error("loop turned off with VCO selected");
   a_prog_frozen: assert property (ctrl_reg.power && $past(ctrl_reg.power) |->
                                   $stable(mult_reg) && $stable(rdiv_reg))
      else $error("programming changed while loop on");
   a_no_joint_switch: assert property (wrCtrl && conflict |=>
                                       $stable(ctrl_reg.power) &&
                                       $stable(ctrl_reg.baseSel))
      else $error("power and select changed in one write");
   a_manual_quiet: assert property (!auto_reg |-> !lockRd ##1 !ctrl_reg.intEn)
      else $error("manual mode shows lock or enable");
   a_irq_on_change: assert property (lockChange && ctrl_reg.intEn |=> lockIrq)
      else $error("lock change gave no interrupt");
   a_lock_sync: assert property (rstn && ctrl_reg.power && auto_reg &&
                                 $past(auto_reg, 2) |-> lockRd ==
                                 $past(detRaw_reg.lock, 2))
      else $error("lock not two stages behind detector");
   a_hold_static: assert property (selState_reg != PLLCG_RUN |=>
                                   $stable(baseClock))
      else $error("base clock moved during switch");
   a_ref_zero_one: assert property (ctrl_reg.power && rdiv_reg == '0 && xtalEdge |->
                                    rdvTick)
      else $error("zero divisor not taken as one");
   a_manual_track: assert property (!auto_reg |-> filterTrack == trackBit_reg)
      else $error("manual filter mode not from software bit");

   c_lock_seen:   cover property (auto_reg && lockChange);
   c_switch_vco:  cover property (selState_reg == PLLCG_SWAP && !srcVco_reg);
   c_conflict:    cover property (wrCtrl && conflict);
   c_flag_race:   cover property (lockChange && flagClr);

endmodule : pllcg_top

// File: dv/pllcg_far_end.sv
// Far-end model: crystal oscillator and analog VCO as plain pin togglers
// Assumes half periods of at least 3 clk cycles, so both pins stay below clk/4
`timescale 1ns/1ps
module pllcg_far_end (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // Run controls from the block
   input  wire logic        oscRun,
   input  wire logic        loopPower,
   // Half periods in clk cycles
   input  wire logic [15:0] xtalHalf,
   input  wire logic [15:0] vcoHalf,
   // Clock pins
   output logic             crystalClock,
   output logic             vcoClock
);
   logic [15:0] xCnt;
   logic [15:0] vCnt;

   // Crystal stands still while the oscillator is disabled
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         xCnt         <= 16'h0000;
         crystalClock <= 1'b0;
      end
      else if (oscRun)
      begin
         xCnt         <= (xCnt >= xtalHalf - 16'h0001) ? 16'h0000 : xCnt + 16'h0001;
         crystalClock <= (xCnt >= xtalHalf - 16'h0001) ? ~crystalClock : crystalClock;
      end
   end

   // VCO is behavioural; the bench shifts its rate to fake a noise hit
   always_ff @(posedge clk)
   begin
      if (!rstn || !loopPower)
      begin
         vCnt     <= 16'h0000;
         vcoClock <= 1'b0;
      end
      else
      begin
         vCnt     <= (vCnt >= vcoHalf - 16'h0001) ? 16'h0000 : vCnt + 16'h0001;
         vcoClock <= (vCnt >= vcoHalf - 16'h0001) ? ~vcoClock : vcoClock;
      end
   end
endmodule : pllcg_far_end

// File: dv/tb.sv
// Testbench of the loop controller: registers, dividers, base clock, lock
// Assumes the far-end model supplies the crystal and VCO pins
`timescale 1ns/1ps
`include "pllcg_cfg.svh"
module tb;
   // ----
   // Signals
   // ----
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        oscEn = 1'b0;
   logic        wr = 1'b0;
   logic        rdS = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [7:0]  wd = 8'h00;
   logic [15:0] xh = 16'h0005;
   logic [15:0] vh = 16'h0003;
   logic [7:0]  rd;
   logic [31:0] cen;
   logic        xc, vc, osc, lrc, frc, fbc, up, dn, trk, pwr, bck, irq;
   logic        seen;
   int          errCount = 0;
   int          cmpCount = 0;
   int          cyc = 0;
   wire  [3:0]  mon = {lrc, bck, fbc, frc};

   always #5 clk = ~clk;

   pllcg_top dut_u (.clk(clk), .rstn(rstn), .oscillatorEnable(oscEn), .crystalClock(xc),
      .vcoClock(vc), .oscRun(osc), .loopReferenceClock(lrc), .finalReferenceClock(frc),
      .vcoFeedbackClock(fbc), .pumpUp(up), .pumpDown(dn), .filterTrack(trk),
      .vcoCentreHz(cen), .loopPower(pwr), .baseClock(bck), .lockIrq(irq), .regAddr(adr),
      .regWdata(wd), .regWr(wr), .regRd(rdS), .regRdata(rd));
   pllcg_far_end far_u (.clk(clk), .rstn(rstn), .oscRun(osc), .loopPower(pwr),
      .xtalHalf(xh), .vcoHalf(vh), .crystalClock(xc), .vcoClock(vc));

   // ----
   // Helpers
   // ----
   function automatic int mx1(input int v);
      return (v == 0) ? 1 : v;
   endfunction : mx1

   function automatic logic [31:0] fCen(input int l, input int e);
      return (l * `PLLCG_NOM_FREQ_HZ) << e;
   endfunction : fCen

   task automatic finalReport();
      if (errCount == 0 && cmpCount > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : finalReport

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmpCount++;
      if (g !== e)
      begin
         errCount++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr  <= 1'b1;
      adr <= a;
      wd  <= d;
      @(posedge clk);
      wr  <= 1'b0;
   endtask : wrReg

   task automatic rdReg(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      rdS <= 1'b1;
      adr <= a;
      @(posedge clk);
      rdS <= 1'b0;
      #1 chk("regRdata", {24'h0, e}, {24'h0, rd});
   endtask : rdReg

   task automatic ctl(input logic [7:0] d, input logic [7:0] e);
      wrReg(`PLLCG_OFS_CTRL, d);
      rdReg(`PLLCG_OFS_CTRL, e);
   endtask : ctl

   // Cycles between the second and third rise of a monitored output
   task automatic per(input int k, input int e);
      int   t;
      int   n;
      int   t0;
      logic pv;
      n  = 0;
      t0 = 0;
      pv = mon[k];
      for (t = 0; t < 4000 && n < 3; t++)
      begin
         @(posedge clk);
         #1;
         if (mon[k] === 1'b1 && pv === 1'b0)
         begin
            n++;
            t0 = (n == 2) ? t : t0;
            if (n == 3)
               chk("period", e, t - t0);
         end
         pv = mon[k];
      end
      if (n < 3)
         chk("period", e, 0);
   endtask : per

   task automatic waitIrq(input int lim);
      int t;
      for (t = 0; t < lim && irq !== 1'b1; t++)
      begin
         @(posedge clk);
         #1;
         seen = seen | up | dn;
      end
      chk("lockIrq", 1, irq);
   endtask : waitIrq

   // Hang guard: the whole sequence needs well under this many cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         errCount++;
         finalReport();
      end
   end

   // ----
   // Sequence
   // ----
   initial
   begin
      int         i;
      int         r;
      int         n;
      int         p;
      logic       b0;
      logic [7:0] ofsT [0:6];
      logic [7:0] rstT [0:6];
      ofsT = '{`PLLCG_OFS_CTRL, `PLLCG_OFS_BW, `PLLCG_OFS_MULTL, `PLLCG_OFS_MULTH,
               `PLLCG_OFS_RANGE, `PLLCG_OFS_RDIV, 8'h3c};
      rstT = '{8'h00, 8'h00, 8'h40, 8'h00, `PLLCG_RST_RANGE, 8'h01, 8'h00};
      i = $urandom(32'h1a2c906d);
      repeat (5) @(posedge clk);
      rstn  <= 1'b1;
      oscEn <= 1'b1;
      for (i = 0; i < 7; i++)
         rdReg(ofsT[i], rstT[i]);
      chk("vcoCentreHz", fCen(64, 0), cen);
      ctl(8'h80, 8'h00);
      ctl(8'h10, 8'h00);
      ctl(8'h30, 8'h00);
      per(3, 2 * xh);
      // Zero divisors first, as they are the corner most likely to be missed
      for (i = 0; i < 4; i++)
      begin
         r = (i == 0) ? 0 : $urandom_range(3, 1);
         n = (i == 0) ? 0 : $urandom_range(4, 1);
         p = $urandom_range(3, 0);
         wrReg(`PLLCG_OFS_RDIV, 8'(r));
         wrReg(`PLLCG_OFS_MULTL, 8'(n));
         ctl({4'h0, 2'(p), 2'b00}, {4'h0, 2'(p), 2'b00});
         ctl({4'h2, 2'(p), 2'b00}, {4'h2, 2'(p), 2'b00});
         per(0, 2 * xh * mx1(r));
         per(1, 2 * vh * (1 << p) * mx1(n));
         wrReg(`PLLCG_OFS_RDIV, 8'h07);
         rdReg(`PLLCG_OFS_RDIV, 8'(r));
         ctl(8'h00, {4'h0, 2'(p), 2'b00});
      end
      per(2, 4 * xh);
      wrReg(`PLLCG_OFS_RANGE, 8'h00);
      ctl(8'h20, 8'h20);
      ctl(8'h30, 8'h20);
      ctl(8'h00, 8'h00);
      wrReg(`PLLCG_OFS_RANGE, 8'h40);
      ctl(8'h20, 8'h20);
      repeat (20) @(posedge clk);
      wrReg(`PLLCG_OFS_BW, 8'h20);
      repeat (20) @(posedge clk);
      ctl(8'h30, 8'h30);
      b0 = bck;
      for (i = 0; i < 12; i++)
      begin
         @(posedge clk);
         #1 chk("baseClock", {31'h0, b0}, {31'h0, bck});
      end
      per(2, 4 * vh);
      ctl(8'h10, 8'h30);
      ctl(8'h00, 8'h30);
      ctl(8'h20, 8'h20);
      ctl(8'h00, 8'h00);
      per(2, 4 * xh);
      for (i = 0; i < 4; i++)
      begin
         r = $urandom_range(255, 0);
         n = $urandom_range(2, 0);
         wrReg(`PLLCG_OFS_RANGE, 8'(r));
         wrReg(`PLLCG_OFS_CTRL, 8'(n));
         repeat (2) @(posedge clk);
         #1 chk("vcoCentreHz", fCen(r, n), cen);
      end
      wrReg(`PLLCG_OFS_BW, 8'h20);
      rdReg(`PLLCG_OFS_BW, 8'h20);
      chk("filterTrack", 1, trk);
      wrReg(`PLLCG_OFS_BW, 8'h00);
      rdReg(`PLLCG_OFS_BW, 8'h00);
      chk("filterTrack", 0, trk);
      @(posedge clk);
      oscEn <= 1'b0;
      for (i = 0; i < 40; i++)
      begin
         @(posedge clk);
         #1;
         if (i > 3)
            chk("loopReferenceClock", 0, lrc);
      end
      chk("oscRun", 0, osc);
      @(posedge clk);
      oscEn <= 1'b1;
      // Reference and feedback both 12 cycles, so the detector should lock
      xh <= 16'h0006;
      wrReg(`PLLCG_OFS_RANGE, 8'h40);
      wrReg(`PLLCG_OFS_RDIV, 8'h01);
      wrReg(`PLLCG_OFS_MULTL, 8'h02);
      wrReg(`PLLCG_OFS_CTRL, 8'h20);
      wrReg(`PLLCG_OFS_BW, 8'h80);
      wrReg(`PLLCG_OFS_CTRL, 8'ha0);
      seen = 1'b0;
      waitIrq(800);
      rdReg(`PLLCG_OFS_BW, 8'he0);
      chk("filterTrack", 1, trk);
      rdReg(`PLLCG_OFS_CTRL, 8'he0);
      @(posedge clk);
      #1 chk("lockIrq", 0, irq);
      ctl(8'hb0, 8'hb0);
      vh = 16'h0032;
      waitIrq(3000);
      rdReg(`PLLCG_OFS_BW, 8'h80);
      ctl(8'ha0, 8'he0);
      chk("pump", 1, seen);
      wrReg(`PLLCG_OFS_BW, 8'h00);
      rdReg(`PLLCG_OFS_CTRL, 8'h20);
      chk("lockIrq", 0, irq);
      finalReport();
   end
endmodule : tb
